// [hw/wwdt_top.sv]
// windowed watchdog timer with avalon-mm register slave
// assumes the cpu monitor inputs are on i_mclk and the low-speed
// oscillator arrives asynchronously as a plain input
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`include "wwdt_consts.svh"
module wwdt_top #(
	parameter int CNT_W = 16,
	parameter int OVF_BASE_LOG2 = 7
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_lsosc,
	input wire logic [7:0] i_option_byte,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_cpu_fetch,
	input wire logic i_cpu_access,
	input wire logic [15:0] i_cpu_addr,
	output logic o_internal_reset,
	output logic o_irq
);
	generate
		if (CNT_W < OVF_BASE_LOG2 + 8 || CNT_W > 31) begin : g_chk
			$error("wwdt_top: CNT_W cannot hold the longest period");
		end
	endgenerate

	// low-speed oscillator synchroniser
	logic osc1_reg, osc2_reg, osc3_reg, osc_lvl_reg, osc_lvl_next;
	logic tick;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			osc1_reg <= 1'b0;
			osc2_reg <= 1'b0;
			osc3_reg <= 1'b0;
		end else begin
			osc1_reg <= i_lsosc;
			osc2_reg <= osc1_reg;
			osc3_reg <= osc2_reg;
		end
	end

	always_comb begin
		osc_lvl_next = osc_lvl_reg;
		if (osc2_reg == osc3_reg) begin
			osc_lvl_next = osc3_reg;
		end
		tick = osc_lvl_next & ~osc_lvl_reg;
	end

	// bus handshake
	logic ack_reg, ack_next, req, wr_go, rd_go;
	logic [31:0] rdata_reg, rdata_next;

	assign req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_reg;
	assign o_avs_readdata = rdata_reg;
	assign wr_go = i_avs_write & ~ack_reg;
	assign rd_go = i_avs_read & ~ack_reg;

	// watchdog state
	wwdt_pkg::wwdt_state_t state_reg, state_next;
	wwdt_pkg::wwdt_fault_t fault;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] period, closed_len;
	logic [3:0] rst_cnt_reg, rst_cnt_next;
	logic first_done_reg, first_done_next;
	logic opt_taken_reg, opt_taken_next;
	logic [7:0] option_reg, option_next;
	logic [7:0] ims_reg, ims_next;
	logic [3:0] ixs_reg, ixs_next;
	logic cause_reg, cause_next;
	logic [1:0] status_reg, status_next;
	logic [1:0] mask_reg, mask_next;
	logic [2:0] ovf_sel;
	logic [1:0] win_sel;
	logic [18:0] mem_limit;
	logic win_open, key_wr, key_ok, cleared;

	always_comb begin
		win_sel = option_reg[`WWDT_WIN_HI_BIT:`WWDT_WIN_LO_BIT];
		ovf_sel = option_reg[`WWDT_OVF_HI_BIT:`WWDT_OVF_LO_BIT];
		period = CNT_W'(1) << (OVF_BASE_LOG2 + int'(ovf_sel));
		// closed part = period * (3 - code) / 4
		closed_len = CNT_W'((period >> 2) * CNT_W'(2'd3 - win_sel));
		win_open = cnt_reg >= closed_len;
		mem_limit = {1'b0, ims_reg, 10'h000} + {3'b000, ixs_reg, 12'h000};
	end

	always_comb begin
		key_wr = wr_go && i_avs_address == `WWDT_OFF_KEY
			&& i_avs_byteenable[0];
		key_ok = i_avs_writedata[7:0] == `WWDT_KEY_VALUE;
		fault = wwdt_pkg::WWDT_F_NONE;
		if (state_reg == wwdt_pkg::WWDT_RUN) begin
			if (tick && cnt_reg == period - CNT_W'(1)) begin
				fault = wwdt_pkg::WWDT_F_OVF;
			end else if (wr_go
				&& i_avs_address == `WWDT_OFF_KEY_BITOP) begin
				fault = wwdt_pkg::WWDT_F_BITOP;
			end else if (key_wr && !key_ok) begin
				fault = wwdt_pkg::WWDT_F_KEY;
			end else if (key_wr && first_done_reg && !win_open) begin
				fault = wwdt_pkg::WWDT_F_CLOSED;
			end else if (i_cpu_fetch && {3'b000, i_cpu_addr} >= mem_limit
				&& i_cpu_addr < `WWDT_EXEMPT_LO) begin
				fault = wwdt_pkg::WWDT_F_FETCH;
			end else if (i_cpu_access
				&& {3'b000, i_cpu_addr} >= mem_limit
				&& i_cpu_addr < `WWDT_EXEMPT_LO) begin
				fault = wwdt_pkg::WWDT_F_ACCESS;
			end
		end
		cleared = state_reg == wwdt_pkg::WWDT_RUN && key_wr && key_ok
			&& fault == wwdt_pkg::WWDT_F_NONE;
	end

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		rst_cnt_next = rst_cnt_reg;
		first_done_next = first_done_reg;
		opt_taken_next = 1'b1;
		option_next = option_reg;
		ims_next = ims_reg;
		ixs_next = ixs_reg;
		cause_next = cause_reg;
		status_next = status_reg;
		mask_next = mask_reg;
		ack_next = req & ~ack_reg;
		rdata_next = rdata_reg;
		// option byte caught once after reset release
		if (!opt_taken_reg) begin
			option_next = i_option_byte;
		end
		case (state_reg)
			wwdt_pkg::WWDT_RUN: begin
				if (fault != wwdt_pkg::WWDT_F_NONE) begin
					state_next = wwdt_pkg::WWDT_RESET;
					rst_cnt_next = `WWDT_RST_CYCLES;
					cnt_next = '0;
					first_done_next = 1'b0;
				end else if (cleared) begin
					cnt_next = '0;
					first_done_next = 1'b1;
				end else if (tick) begin
					cnt_next = cnt_reg + CNT_W'(1);
				end
			end
			wwdt_pkg::WWDT_RESET: begin
				rst_cnt_next = rst_cnt_reg - 4'h1;
				if (rst_cnt_reg == 4'h1) begin
					state_next = wwdt_pkg::WWDT_RUN;
				end
			end
			default: begin
				state_next = wwdt_pkg::WWDT_RUN;
			end
		endcase
		// register writes
		if (wr_go && i_avs_address == `WWDT_OFF_MEMSIZE) begin
			if (i_avs_byteenable[0]) begin
				ims_next = i_avs_writedata[7:0];
			end
			if (i_avs_byteenable[1]) begin
				ixs_next = i_avs_writedata[11:8];
			end
		end
		if (wr_go && i_avs_address == `WWDT_OFF_MASK
			&& i_avs_byteenable[0]) begin
			mask_next = i_avs_writedata[1:0];
		end
		// reads, with read-to-clear flags
		if (rd_go) begin
			rdata_next = '0;
			case (i_avs_address)
				`WWDT_OFF_MEMSIZE: rdata_next[11:0] = {ixs_reg, ims_reg};
				`WWDT_OFF_RESET_CAUSE: begin
					rdata_next[`WWDT_CAUSE_BIT] = cause_reg;
					cause_next = 1'b0;
				end
				`WWDT_OFF_STATUS: begin
					rdata_next[1:0] = status_reg;
					status_next = 2'b00;
				end
				`WWDT_OFF_MASK: rdata_next[1:0] = mask_reg;
				`WWDT_OFF_COUNT: rdata_next[CNT_W-1:0] = cnt_reg;
				`WWDT_OFF_OPTION: rdata_next[7:0] = option_reg;
				default: rdata_next = '0;
			endcase
		end
		// hardware set wins over read clear
		if (fault != wwdt_pkg::WWDT_F_NONE) begin
			cause_next = 1'b1;
			status_next[`WWDT_ST_FAULT] = 1'b1;
		end
		if (cleared) begin
			status_next[`WWDT_ST_CLEARED] = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			osc_lvl_reg <= 1'b0;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			state_reg <= wwdt_pkg::WWDT_RUN;
			cnt_reg <= '0;
			rst_cnt_reg <= 4'h0;
			first_done_reg <= 1'b0;
			opt_taken_reg <= 1'b0;
			option_reg <= 8'hff;
			ims_reg <= `WWDT_IMS_RESET;
			ixs_reg <= `WWDT_IXS_RESET;
			cause_reg <= 1'b0;
			status_reg <= 2'b00;
			mask_reg <= 2'b00;
		end else begin
			osc_lvl_reg <= osc_lvl_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			rst_cnt_reg <= rst_cnt_next;
			first_done_reg <= first_done_next;
			opt_taken_reg <= opt_taken_next;
			option_reg <= option_next;
			ims_reg <= ims_next;
			ixs_reg <= ixs_next;
			cause_reg <= cause_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
		end
	end

	assign o_internal_reset = state_reg == wwdt_pkg::WWDT_RESET;
	assign o_irq = |(status_reg & mask_reg);
endmodule

// [hw/wwdt_consts.svh]
// constants for the windowed watchdog: offsets, fields, resets, timing
// assumes a 32-bit avalon-mm slave with byte addresses
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH
`define WWDT_OFF_KEY 6'h00
`define WWDT_OFF_KEY_BITOP 6'h04
`define WWDT_OFF_MEMSIZE 6'h08
`define WWDT_OFF_RESET_CAUSE 6'h0c
`define WWDT_OFF_STATUS 6'h10
`define WWDT_OFF_MASK 6'h14
`define WWDT_OFF_COUNT 6'h18
`define WWDT_OFF_OPTION 6'h1c
`define WWDT_KEY_VALUE 8'hac
`define WWDT_OPTION_ADDR 16'h0080
`define WWDT_WIN_HI_BIT 6
`define WWDT_WIN_LO_BIT 5
`define WWDT_OVF_HI_BIT 3
`define WWDT_OVF_LO_BIT 1
`define WWDT_CAUSE_BIT 4
`define WWDT_EXEMPT_LO 16'hfb00
`define WWDT_IMS_RESET 8'h10
`define WWDT_IXS_RESET 4'h0
`define WWDT_RST_CYCLES 4'h8
`define WWDT_ST_CLEARED 0
`define WWDT_ST_FAULT 1
`endif

// [hw/wwdt_pkg.sv]
// types shared by the windowed watchdog
// assumes nothing beyond a systemverilog compiler
package wwdt_pkg;
	typedef enum logic {WWDT_RUN, WWDT_RESET} wwdt_state_t;
	typedef enum logic [2:0] {
		WWDT_F_NONE, WWDT_F_OVF, WWDT_F_BITOP, WWDT_F_KEY,
		WWDT_F_CLOSED, WWDT_F_FETCH, WWDT_F_ACCESS
	} wwdt_fault_t;
endpackage

// [dv/wwdt_top_assertions.sv]
// port checker for the windowed watchdog
// assumes bind onto wwdt_top and memsize left at its reset value
`include "wwdt_consts.svh"
module wwdt_chk #(
	parameter int CNT_W = 16,
	parameter int OVF_BASE_LOG2 = 7
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_option_byte,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_cpu_fetch,
	input wire logic i_cpu_access,
	input wire logic [15:0] i_cpu_addr,
	input wire logic o_internal_reset
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	logic seen_reg, seen_next;
	wire wq = i_avs_write && o_avs_waitrequest && !o_internal_reset;
	wire key = i_avs_address == `WWDT_OFF_KEY && i_avs_byteenable[0];
	wire ok = i_avs_writedata[7:0] == `WWDT_KEY_VALUE;
	// 16 kib internal area at reset
	wire bad = i_cpu_addr >= 16'h4000 && i_cpu_addr < `WWDT_EXEMPT_LO
		&& !o_internal_reset;
	wire crd = i_avs_read && !o_avs_waitrequest
		&& i_avs_address == `WWDT_OFF_RESET_CAUSE;
	always_comb begin
		seen_next = seen_reg;
		if (crd)
			seen_next = 1'b0;
		if (o_internal_reset)
			seen_next = 1'b1;
	end
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			seen_reg <= 1'b0;
		else
			seen_reg <= seen_next;
	end
	a_one_wait: assert property ((i_avs_read || i_avs_write)
		&& o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no ack");
	a_reset_len: assert property ($rose(o_internal_reset) |->
		o_internal_reset[*8] ##1 !o_internal_reset) else $error("pulse");
	a_bitop_rst: assert property (wq &&
		i_avs_address == `WWDT_OFF_KEY_BITOP |=> o_internal_reset)
		else $error("bit op kept");
	a_bad_key: assert property (wq && key && !ok
		|=> o_internal_reset) else $error("bad key kept");
	a_full_win: assert property (wq && key && ok
		&& i_option_byte[6:5] == 2'b11 |=> !o_internal_reset)
		else $error("open key reset");
	a_fetch_rst: assert property (i_cpu_fetch && bad
		|=> o_internal_reset) else $error("fetch kept");
	a_access_rst: assert property (i_cpu_access && bad
		|=> o_internal_reset) else $error("access kept");
	a_cause_flag: assert property (crd && seen_reg
		|-> o_avs_readdata[`WWDT_CAUSE_BIT]) else $error("cause lost");
endmodule
bind wwdt_top wwdt_chk #(.CNT_W(CNT_W), .OVF_BASE_LOG2(OVF_BASE_LOG2))
	wwdt_chk_inst (.*);

// [dv/wwdt_top_tb_top.sv]
// bench for the windowed watchdog: avalon reads and writes, cpu pulses
// assumes short periods via parameters and the bound port checker
`include "wwdt_consts.svh"
module wwdt_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, osc = 0, rd = 0, wr = 0, fe = 0, ac = 0;
	logic rq, irst, irq;
	logic [7:0] opt = 8'h02;
	logic [5:0] adr = 6'h00;
	logic [15:0] ca = 16'h0000;
	logic [31:0] wd = 32'h0, rdat, q;
	int error_cnt = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	wwdt_top #(.CNT_W(15), .OVF_BASE_LOG2(2)) wwdt_top_inst (.i_mclk(clk),
		.i_reset_n(rst_n), .i_lsosc(osc), .i_option_byte(opt),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(rq), .i_cpu_fetch(fe),
		.i_cpu_access(ac), .i_cpu_addr(ca), .o_internal_reset(irst),
		.o_irq(irq));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// read compares masked data with d
	task automatic bus(input logic r, input logic [5:0] a,
		input logic [31:0] d, input logic [31:0] m = 32'hffffffff);
		@(posedge clk);
		rd <= r;
		wr <= !r;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (rq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (r)
			chk(q & m, d);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk) osc <= 1'b1;
			repeat (6) @(posedge clk);
			osc <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic cpu(input logic f, input logic [15:0] a);
		@(posedge clk);
		fe <= f;
		ac <= !f;
		ca <= a;
		@(posedge clk);
		fe <= 1'b0;
		ac <= 1'b0;
	endtask
	task automatic rchk(input logic e);
		repeat (2) @(posedge clk);
		chk({31'h0, irst}, {31'h0, e});
		repeat (10) @(posedge clk);
	endtask
	task automatic start(input logic [7:0] o);
		@(posedge clk);
		rst_n <= 1'b0;
		opt <= o;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	initial begin
		start(8'h02);
		bus(1, `WWDT_OFF_MEMSIZE, 32'h10);
		bus(1, 6'h20, 32'h0);
		bus(1, `WWDT_OFF_OPTION, 32'h02, 32'hff);
		tick(2);
		bus(1, `WWDT_OFF_COUNT, 32'h2);
		bus(0, `WWDT_OFF_KEY, 32'hac);
		rchk(0);
		bus(0, `WWDT_OFF_KEY, 32'hac);
		rchk(1);
		bus(1, `WWDT_OFF_RESET_CAUSE, 32'h10, 32'h10);
		bus(1, `WWDT_OFF_RESET_CAUSE, 32'h0, 32'h10);
		bus(0, `WWDT_OFF_KEY, 32'hac);
		tick(7);
		rchk(0);
		tick(1);
		rchk(1);
		bus(0, `WWDT_OFF_KEY, 32'h55);
		rchk(1);
		bus(0, `WWDT_OFF_KEY_BITOP, 32'h0);
		rchk(1);
		cpu(1, 16'h3fff);
		rchk(0);
		cpu(1, 16'h4000);
		rchk(1);
		cpu(0, 16'hfb00);
		rchk(0);
		cpu(0, 16'hfaff);
		rchk(1);
		bus(1, `WWDT_OFF_STATUS, 32'h3, 32'h3);
		bus(0, `WWDT_OFF_MASK, 32'h0);
		bus(0, `WWDT_OFF_KEY, 32'h55);
		rchk(1);
		chk({31'h0, irq}, 32'h0);
		bus(0, `WWDT_OFF_MASK, 32'h2);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1, `WWDT_OFF_STATUS, 32'h2, 32'h2);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		for (int c = 0; c < 4; c++) begin
			start({1'b0, c[1:0], 5'h02});
			bus(0, `WWDT_OFF_KEY, 32'hac);
			tick(6 - 2 * c);
			bus(0, `WWDT_OFF_KEY, 32'hac);
			rchk(0);
			bus(1, `WWDT_OFF_COUNT, 32'h0);
			if (c < 3) begin
				tick(5 - 2 * c);
				bus(0, `WWDT_OFF_KEY, 32'hac);
				rchk(1);
			end
		end
		end_sim;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_sim;
	end
endmodule
